// File: verilog/occ_defines.vh
`ifndef OCC_DEFINES_VH
`define OCC_DEFINES_VH

// Register byte addresses
`define OCC_ADDR_CTRL        12'h000
`define OCC_ADDR_DITHER      12'h004
`define OCC_ADDR_BRIGHT      12'h008
`define OCC_ADDR_CONTRAST    12'h00C
`define OCC_ADDR_STATUS      12'h010
`define OCC_ADDR_GAIN_BASE   12'h100
`define OCC_ADDR_THRESH_BASE 12'h200
`define OCC_ADDR_TABLE_MASK  12'hF00

// Control register fields
`define OCC_CTRL_ORDER       0
`define OCC_CTRL_DITHER_EN   1
`define OCC_CTRL_METHOD_LSB  2
`define OCC_CTRL_BRIGHT_EN   4
`define OCC_CTRL_CONTRAST_EN 5
`define OCC_CTRL_GAMMA_EN    6
`define OCC_CTRL_WIDTH       7

// Dither methods
`define OCC_METHOD_TRUNC     2'h0
`define OCC_METHOD_ROUND     2'h1
`define OCC_METHOD_PATTERN   2'h2

// Reset values
`define OCC_CTRL_RESET       7'h00
`define OCC_DITHER_RESET     8'h00
`define OCC_BRIGHT_RESET     24'h000000
`define OCC_CONTRAST_RESET   24'h808080
`define OCC_UNITY_GAIN       8'h80
`define OCC_GAIN_SHIFT       7

// AXI responses
`define OCC_RESP_OKAY        2'h0
`define OCC_RESP_SLVERR      2'h2

`endif

// File: verilog/occ_top.v
// Register access over AXI4-Lite and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
// Behaviour
// - Control bit picks brightness/contrast then gamma, or gamma then brightness/contrast.
// - Dither disabled means plain truncation; method and pattern values are ignored.
// - Dither enabled: method 0 truncates, 1 rounds, 2 applies 2x2 ordered pattern.
// - Four pattern cell values, used only while the ordered pattern method is selected.
// - Brightness disabled forces a zero offset on all three channels.
// - Brightness enabled adds a separate signed offset per red, green, blue.
// - Contrast disabled forces unity gain on all three channels.
// - Contrast enabled multiplies each channel by its own programmed gain.
// - Gamma disabled passes components unchanged, ignoring gains and thresholds.
// - Each channel holds sixteen area gains and fifteen area start thresholds.
`include "occ_defines.vh"
module occ_top (
    input  wire        mclk_in,
    input  wire        rst_n_in,
    input  wire [11:0] s_axi_awaddr_in,
    input  wire        s_axi_awvalid_in,
    output reg         s_axi_awready_out,
    input  wire [31:0] s_axi_wdata_in,
    input  wire [3:0]  s_axi_wstrb_in,
    input  wire        s_axi_wvalid_in,
    output reg         s_axi_wready_out,
    output reg  [1:0]  s_axi_bresp_out,
    output reg         s_axi_bvalid_out,
    input  wire        s_axi_bready_in,
    input  wire [11:0] s_axi_araddr_in,
    input  wire        s_axi_arvalid_in,
    output reg         s_axi_arready_out,
    output reg  [31:0] s_axi_rdata_out,
    output reg  [1:0]  s_axi_rresp_out,
    output reg         s_axi_rvalid_out,
    input  wire        s_axi_rready_in,
    input  wire        pix_valid_in,
    output reg         pix_ready_out,
    input  wire [23:0] pix_rgb_in,
    input  wire        pix_de_in,
    input  wire        pix_hsync_in,
    input  wire        pix_vsync_in,
    output reg         panel_valid_out,
    input  wire        panel_ready_in,
    output reg  [17:0] panel_rgb_out,
    output reg         panel_de_out,
    output reg         panel_hsync_out,
    output reg         panel_vsync_out
);
    reg [`OCC_CTRL_WIDTH-1:0] ctrl_r;
    reg [7:0]                 dither_r;
    reg [23:0]                bright_r;
    reg [23:0]                contrast_r;
    reg [7:0]                 gamma_gain_r   [0:47];
    reg [7:0]                 gamma_thresh_r [0:47];
    reg [11:0] awaddr_r;
    reg        aw_held_r;
    reg [31:0] wdata_r;
    reg [3:0]  wstrb_r;
    reg        w_held_r;
    reg [26:0] buf_mem_r [0:1];
    reg        buf_wr_ptr_r;
    reg        buf_rd_ptr_r;
    reg [1:0]  buf_cnt_r;
    reg [1:0]  buf_cnt_nxt;
    reg        s1_valid_r;
    reg [23:0] s1_rgb_r;
    reg [2:0]  s1_sync_r;
    reg [1:0]  s1_cell_r;
    reg        col_r;
    reg        row_r;
    reg        last_de_r;
    integer    i;
    wire       order_gamma_first = ctrl_r[`OCC_CTRL_ORDER];
    wire       dither_en         = ctrl_r[`OCC_CTRL_DITHER_EN];
    wire [1:0] dither_method     = ctrl_r[`OCC_CTRL_METHOD_LSB+1:`OCC_CTRL_METHOD_LSB];
    wire       bright_en         = ctrl_r[`OCC_CTRL_BRIGHT_EN];
    wire       contrast_en       = ctrl_r[`OCC_CTRL_CONTRAST_EN];
    wire       gamma_en          = ctrl_r[`OCC_CTRL_GAMMA_EN];
    // Address class: 0 unmapped, 1 plain register, 2 gain table, 3 threshold table
    function [1:0] addr_class;
        input [11:0] a;
        begin
            addr_class = 2'h0;
            if (a == `OCC_ADDR_CTRL || a == `OCC_ADDR_DITHER || a == `OCC_ADDR_BRIGHT ||
                a == `OCC_ADDR_CONTRAST || a == `OCC_ADDR_STATUS)
                addr_class = 2'h1;
            else if ((a & `OCC_ADDR_TABLE_MASK) == `OCC_ADDR_GAIN_BASE && a[7:6] != 2'h3 && a[1:0] == 2'h0)
                addr_class = 2'h2;
            else if ((a & `OCC_ADDR_TABLE_MASK) == `OCC_ADDR_THRESH_BASE && a[7:6] != 2'h3 &&
                     a[5:2] != 4'h0 && a[1:0] == 2'h0)
                addr_class = 2'h3;
        end
    endfunction
    function [7:0] sat8;
        input signed [17:0] v;
        begin
            if (v < 0)
                sat8 = 8'h00;
            else if (v > 18'sd255)
                sat8 = 8'hFF;
            else
                sat8 = v[7:0];
        end
    endfunction
    // Offset then gain; disabled stages fall back to zero and unity
    function [7:0] bright_contrast;
        input [7:0] x;
        input [7:0] off;
        input [7:0] gain;
        reg   [7:0] u;
        reg   [7:0] g;
        reg   [15:0] p;
        begin
            u = sat8($signed({10'h000, x}) + (bright_en ? $signed({{10{off[7]}}, off}) : 18'sd0));
            g = contrast_en ? gain : `OCC_UNITY_GAIN;
            p = u * g;
            bright_contrast = sat8($signed({9'h000, p[15:`OCC_GAIN_SHIFT]}));
        end
    endfunction
    // Piecewise linear curve; thresholds must be programmed ascending
    function [7:0] gamma;
        input [7:0] x;
        input [1:0] ch;
        integer     k;
        reg   [5:0] base;
        reg   [5:0] area;
        reg   [7:0] prev;
        reg   [13:0] acc;
        reg   [15:0] p;
        begin
            base = {ch, 4'h0};
            area = base;
            prev = 8'h00;
            acc  = 14'h0000;
            for (k = 1; k < 16; k = k + 1) begin
                if (x >= gamma_thresh_r[base + k]) begin
                    p    = gamma_gain_r[area] * (gamma_thresh_r[base + k] - prev);
                    acc  = acc + p[15:`OCC_GAIN_SHIFT];
                    prev = gamma_thresh_r[base + k];
                    area = base + k[5:0];
                end
            end
            p   = gamma_gain_r[area] * (x - prev);
            acc = acc + p[15:`OCC_GAIN_SHIFT];
            if (!gamma_en)
                gamma = x;
            else if (acc[13:8] != 6'h00)
                gamma = 8'hFF;
            else
                gamma = acc[7:0];
        end
    endfunction
    function [5:0] reduce;
        input [7:0] x;
        input [1:0] cell_val;
        reg   [6:0] s;
        begin
            s = {1'b0, x[7:2]};
            if (dither_en && dither_method == `OCC_METHOD_ROUND)
                s = s + {6'h00, x[1]};
            else if (dither_en && dither_method == `OCC_METHOD_PATTERN && x[1:0] > cell_val)
                s = s + 7'h01;
            reduce = s[6] ? 6'h3F : s[5:0];
        end
    endfunction

    function [7:0] stage;
        input [7:0] x;
        input [1:0] ch;
        input [7:0] off;
        input [7:0] gain;
        input       first;
        begin
            stage = (order_gamma_first == first) ? gamma(x, ch) : bright_contrast(x, off, gain);
        end
    endfunction
    // Register write path
    wire       aw_fire   = s_axi_awvalid_in && s_axi_awready_out;
    wire       w_fire    = s_axi_wvalid_in && s_axi_wready_out;
    wire       do_write  = aw_held_r && w_held_r && !s_axi_bvalid_out;
    wire [1:0] wr_class  = addr_class(awaddr_r);
    wire [5:0] wr_index  = {awaddr_r[7:6], awaddr_r[5:2]};
    always @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_axi_awready_out <= 1'b1;
            s_axi_wready_out  <= 1'b1;
            s_axi_bvalid_out  <= 1'b0;
            s_axi_bresp_out   <= `OCC_RESP_OKAY;
            aw_held_r         <= 1'b0;
            w_held_r          <= 1'b0;
            awaddr_r          <= 12'h000;
            wdata_r           <= 32'h00000000;
            wstrb_r           <= 4'h0;
            ctrl_r            <= `OCC_CTRL_RESET;
            dither_r          <= `OCC_DITHER_RESET;
            bright_r          <= `OCC_BRIGHT_RESET;
            contrast_r        <= `OCC_CONTRAST_RESET;
            for (i = 0; i < 48; i = i + 1) begin
                gamma_gain_r[i]   <= `OCC_UNITY_GAIN;
                gamma_thresh_r[i] <= {i[3:0], 4'h0};
            end
        end else begin
            if (aw_fire) begin
                awaddr_r          <= s_axi_awaddr_in;
                aw_held_r         <= 1'b1;
                s_axi_awready_out <= 1'b0;
            end
            if (w_fire) begin
                wdata_r          <= s_axi_wdata_in;
                wstrb_r          <= s_axi_wstrb_in;
                w_held_r         <= 1'b1;
                s_axi_wready_out <= 1'b0;
            end
            if (do_write) begin
                aw_held_r        <= 1'b0;
                w_held_r         <= 1'b0;
                s_axi_bvalid_out <= 1'b1;
                s_axi_bresp_out  <= (wr_class == 2'h0) ? `OCC_RESP_SLVERR : `OCC_RESP_OKAY;
                if (wr_class == 2'h1 && wstrb_r[0]) begin
                    case (awaddr_r)
                        `OCC_ADDR_CTRL:     ctrl_r     <= wdata_r[`OCC_CTRL_WIDTH-1:0];
                        `OCC_ADDR_DITHER:   dither_r   <= wdata_r[7:0];
                        `OCC_ADDR_BRIGHT:   bright_r[7:0]   <= wdata_r[7:0];
                        `OCC_ADDR_CONTRAST: contrast_r[7:0] <= wdata_r[7:0];
                        default:            ;
                    endcase
                end
                if (wr_class == 2'h1 && awaddr_r == `OCC_ADDR_BRIGHT) begin
                    if (wstrb_r[1])
                        bright_r[15:8] <= wdata_r[15:8];
                    if (wstrb_r[2])
                        bright_r[23:16] <= wdata_r[23:16];
                end
                if (wr_class == 2'h1 && awaddr_r == `OCC_ADDR_CONTRAST) begin
                    if (wstrb_r[1])
                        contrast_r[15:8] <= wdata_r[15:8];
                    if (wstrb_r[2])
                        contrast_r[23:16] <= wdata_r[23:16];
                end
                if (wr_class == 2'h2 && wstrb_r[0])
                    gamma_gain_r[wr_index] <= wdata_r[7:0];
                if (wr_class == 2'h3 && wstrb_r[0])
                    gamma_thresh_r[wr_index] <= wdata_r[7:0];
            end
            if (s_axi_bvalid_out && s_axi_bready_in) begin
                s_axi_bvalid_out  <= 1'b0;
                s_axi_awready_out <= 1'b1;
                s_axi_wready_out  <= 1'b1;
            end
        end
    end
    // Register read path, answer one cycle after the address is taken
    wire       ar_fire  = s_axi_arvalid_in && s_axi_arready_out;
    wire [1:0] rd_class = addr_class(s_axi_araddr_in);
    wire [5:0] rd_index = {s_axi_araddr_in[7:6], s_axi_araddr_in[5:2]};
    reg  [31:0] rd_data;
    always @* begin
        rd_data = 32'h00000000;
        case (rd_class)
            2'h1: begin
                case (s_axi_araddr_in)
                    `OCC_ADDR_CTRL:     rd_data = {25'h0000000, ctrl_r};
                    `OCC_ADDR_DITHER:   rd_data = {24'h000000, dither_r};
                    `OCC_ADDR_BRIGHT:   rd_data = {8'h00, bright_r};
                    `OCC_ADDR_CONTRAST: rd_data = {8'h00, contrast_r};
                    `OCC_ADDR_STATUS:   rd_data = {26'h0000000, row_r, col_r, s1_valid_r,
                                                   panel_valid_out, buf_cnt_r};
                    default:            rd_data = 32'h00000000;
                endcase
            end
            2'h2:    rd_data = {24'h000000, gamma_gain_r[rd_index]};
            2'h3:    rd_data = {24'h000000, gamma_thresh_r[rd_index]};
            default: rd_data = 32'h00000000;
        endcase
    end
    always @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_axi_arready_out <= 1'b1;
            s_axi_rvalid_out  <= 1'b0;
            s_axi_rdata_out   <= 32'h00000000;
            s_axi_rresp_out   <= `OCC_RESP_OKAY;
        end else if (ar_fire) begin
            s_axi_arready_out <= 1'b0;
            s_axi_rvalid_out  <= 1'b1;
            s_axi_rdata_out   <= rd_data;
            s_axi_rresp_out   <= (rd_class == 2'h0) ? `OCC_RESP_SLVERR : `OCC_RESP_OKAY;
        end else if (s_axi_rvalid_out && s_axi_rready_in) begin
            s_axi_rvalid_out  <= 1'b0;
            s_axi_arready_out <= 1'b1;
        end
    end
    // Two-entry input buffer; ready is a flop so the blender sees no combinational path
    wire        advance = !panel_valid_out || panel_ready_in;
    wire        push    = pix_valid_in && pix_ready_out;
    wire        pop     = (buf_cnt_r != 2'h0) && advance;
    wire [26:0] head    = buf_mem_r[buf_rd_ptr_r];
    wire        head_de = head[26];
    always @* begin
        buf_cnt_nxt = buf_cnt_r;
        if (push && !pop)
            buf_cnt_nxt = buf_cnt_r + 2'h1;
        else if (pop && !push)
            buf_cnt_nxt = buf_cnt_r - 2'h1;
    end
    always @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            buf_mem_r[0]  <= 27'h0000000;
            buf_mem_r[1]  <= 27'h0000000;
            buf_wr_ptr_r  <= 1'b0;
            buf_rd_ptr_r  <= 1'b0;
            buf_cnt_r     <= 2'h0;
            pix_ready_out <= 1'b1;
        end else begin
            if (push) begin
                buf_mem_r[buf_wr_ptr_r] <= {pix_de_in, pix_hsync_in, pix_vsync_in, pix_rgb_in};
                buf_wr_ptr_r            <= ~buf_wr_ptr_r;
            end
            if (pop)
                buf_rd_ptr_r <= ~buf_rd_ptr_r;
            buf_cnt_r     <= buf_cnt_nxt;
            pix_ready_out <= (buf_cnt_nxt != 2'h2);
        end
    end
    // Two-stage pipeline that stalls as one unit when the panel side holds off
    always @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s1_valid_r      <= 1'b0;
            s1_rgb_r        <= 24'h000000;
            s1_sync_r       <= 3'h0;
            s1_cell_r       <= 2'h0;
            col_r           <= 1'b0;
            row_r           <= 1'b0;
            last_de_r       <= 1'b0;
            panel_valid_out <= 1'b0;
            panel_rgb_out   <= 18'h00000;
            panel_de_out    <= 1'b0;
            panel_hsync_out <= 1'b0;
            panel_vsync_out <= 1'b0;
        end else if (advance) begin
            s1_valid_r <= pop;
            if (pop) begin
                s1_rgb_r  <= {stage(head[23:16], 2'h0, bright_r[23:16], contrast_r[23:16], 1'b1),
                              stage(head[15:8],  2'h1, bright_r[15:8],  contrast_r[15:8],  1'b1),
                              stage(head[7:0],   2'h2, bright_r[7:0],   contrast_r[7:0],   1'b1)};
                s1_sync_r <= head[26:24];
                s1_cell_r <= {row_r, col_r};
                col_r     <= head_de ? ~col_r : 1'b0;
                last_de_r <= head_de;
                if (head[24])
                    row_r <= 1'b0;
                else if (last_de_r && !head_de)
                    row_r <= ~row_r;
            end
            panel_valid_out <= s1_valid_r;
            if (s1_valid_r) begin
                panel_rgb_out   <= {reduce(stage(s1_rgb_r[23:16], 2'h0, bright_r[23:16], contrast_r[23:16], 1'b0),
                                           dither_r[{s1_cell_r, 1'b0} +: 2]),
                                    reduce(stage(s1_rgb_r[15:8],  2'h1, bright_r[15:8],  contrast_r[15:8],  1'b0),
                                           dither_r[{s1_cell_r, 1'b0} +: 2]),
                                    reduce(stage(s1_rgb_r[7:0],   2'h2, bright_r[7:0],   contrast_r[7:0],   1'b0),
                                           dither_r[{s1_cell_r, 1'b0} +: 2])};
                panel_de_out    <= s1_sync_r[2];
                panel_hsync_out <= s1_sync_r[1];
                panel_vsync_out <= s1_sync_r[0];
            end
        end
    end
endmodule // occ_top

// File: dv/occ_panel_model.sv
`timescale 1ns/10ps
module occ_panel_model (
    input  wire  mclk_in,
    input  wire  rst_n_in,
    input  wire  panel_valid_out,
    output logic panel_ready_in
);
    // Stalls half the offered cycles, so the input buffer fills and refuses
    always @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in)
            panel_ready_in <= 1'b0;
        else
            panel_ready_in <= panel_valid_out ? (($urandom % 8) > 3) : 1'b1;
    end
endmodule // occ_panel_model

// File: dv/occ_top_chk.sv
`timescale 1ns/10ps
module occ_top_chk (
    input wire        mclk_in,
    input wire        rst_n_in,
    input wire        s_axi_awvalid_in,
    input wire        s_axi_awready_out,
    input wire        s_axi_wvalid_in,
    input wire        s_axi_wready_out,
    input wire [1:0]  s_axi_bresp_out,
    input wire        s_axi_bvalid_out,
    input wire        s_axi_bready_in,
    input wire        s_axi_arvalid_in,
    input wire        s_axi_arready_out,
    input wire [31:0] s_axi_rdata_out,
    input wire        s_axi_rvalid_out,
    input wire        s_axi_rready_in,
    input wire        pix_valid_in,
    input wire        pix_ready_out,
    input wire        panel_valid_out,
    input wire        panel_ready_in,
    input wire [17:0] panel_rgb_out,
    input wire        panel_de_out,
    input wire        panel_hsync_out,
    input wire        panel_vsync_out
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);
    wr_answer_a: assert property (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out
        |=> ##1 s_axi_bvalid_out) else $error("write response late");
    rd_answer_a: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
        else $error("read response late");
    b_hold_a: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
        else $error("write response dropped");
    r_hold_a: assert property (s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
        else $error("read data dropped");
    b_done_a: assert property (s_axi_bvalid_out && s_axi_bready_in
        |=> !s_axi_bvalid_out && s_axi_awready_out && s_axi_wready_out) else $error("write not closed");
    r_done_a: assert property (s_axi_rvalid_out && s_axi_rready_in |=> !s_axi_rvalid_out && s_axi_arready_out)
        else $error("read not closed");
    panel_hold_a: assert property (panel_valid_out && !panel_ready_in |=> panel_valid_out
        && $stable({panel_rgb_out, panel_de_out, panel_hsync_out, panel_vsync_out})) else $error("pixel changed");
    pix_latency_a: assert property (pix_valid_in && pix_ready_out && panel_ready_in ##1 panel_ready_in
        |=> ##1 panel_valid_out) else $error("pixel latency");
endmodule // occ_top_chk

bind occ_top occ_top_chk u_chk (.mclk_in, .rst_n_in, .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wvalid_in,
    .s_axi_wready_out, .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_arvalid_in, .s_axi_arready_out,
    .s_axi_rdata_out, .s_axi_rvalid_out, .s_axi_rready_in, .pix_valid_in, .pix_ready_out, .panel_valid_out,
    .panel_ready_in, .panel_rgb_out, .panel_de_out, .panel_hsync_out, .panel_vsync_out);

// File: dv/test_output_color_correction.sv
`timescale 1ns/10ps
module test_output_color_correction;
    logic        mclk_in, rst_n_in, s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in;
    logic        s_axi_rready_in, pix_valid_in, pix_de_in, pix_hsync_in, pix_vsync_in, row, col, pde;
    logic [11:0] s_axi_awaddr_in, s_axi_araddr_in;
    logic [31:0] s_axi_wdata_in, w;
    logic [3:0]  s_axi_wstrb_in;
    logic [23:0] pix_rgb_in, brt, con;
    wire         s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out;
    wire         pix_ready_out, panel_valid_out, panel_ready_in, panel_de_out, panel_hsync_out, panel_vsync_out;
    wire  [1:0]  s_axi_bresp_out, s_axi_rresp_out;
    wire  [31:0] s_axi_rdata_out;
    wire  [17:0] panel_rgb_out;
    wire  [20:0] panel_word = {panel_de_out, panel_hsync_out, panel_vsync_out, panel_rgb_out};
    int          error_cnt, checks_done, cyc, gg[3][16];
    logic [20:0] exp_q[$];
    logic [7:0]  dth;
    logic [6:0]  ctrl;
    logic [11:0] ra[7] = '{12'h000, 12'h004, 12'h008, 12'h00C, 12'h010, 12'h104, 12'h20C};
    logic [31:0] rv[7] = '{32'h0, 32'h0, 32'h0, 32'h808080, 32'h0, 32'h80, 32'h30};

    occ_top DUT (.mclk_in, .rst_n_in, .s_axi_awaddr_in, .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wdata_in,
        .s_axi_wstrb_in, .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in,
        .s_axi_araddr_in, .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out, .s_axi_rresp_out,
        .s_axi_rvalid_out, .s_axi_rready_in, .pix_valid_in, .pix_ready_out, .pix_rgb_in, .pix_de_in, .pix_hsync_in,
        .pix_vsync_in, .panel_valid_out, .panel_ready_in, .panel_rgb_out, .panel_de_out, .panel_hsync_out,
        .panel_vsync_out);
    occ_panel_model u_panel (.mclk_in, .rst_n_in, .panel_valid_out, .panel_ready_in);

    initial begin
        mclk_in = 1'b0;
        forever #10 mclk_in = ~mclk_in;
    end

    task automatic end_of_test();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ad, wd;
        ad = 0;
        wd = 0;
        s_axi_awaddr_in <= a;
        s_axi_wdata_in <= d;
        s_axi_awvalid_in <= 1'b1;
        s_axi_wvalid_in <= 1'b1;
        s_axi_bready_in <= 1'b1;
        do begin
            @(posedge mclk_in);
            if (!ad && s_axi_awready_out) begin
                ad = 1;
                s_axi_awvalid_in <= 1'b0;
            end
            if (!wd && s_axi_wready_out) begin
                wd = 1;
                s_axi_wvalid_in <= 1'b0;
            end
        end while (!(ad && wd && s_axi_bvalid_out));
        chk("bresp", s_axi_bresp_out, er);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
        logic ad;
        ad = 0;
        s_axi_araddr_in <= a;
        s_axi_arvalid_in <= 1'b1;
        s_axi_rready_in <= 1'b1;
        do begin
            @(posedge mclk_in);
            if (!ad && s_axi_arready_out) begin
                ad = 1;
                s_axi_arvalid_in <= 1'b0;
            end
        end while (!(ad && s_axi_rvalid_out));
        chk("rdata", s_axi_rdata_out, e);
        chk("rresp", s_axi_rresp_out, er);
    endtask

    function automatic int sat(input int v, input int m);
        return v < 0 ? 0 : (v > m ? m : v);
    endfunction

    function automatic int bc(input int x, input int c);
        int o, g;
        o = ctrl[4] ? int'($signed(brt[c*8+:8])) : 0;
        g = ctrl[5] ? int'(con[c*8+:8]) : 128;
        return sat(sat(x + o, 255) * g >> 7, 255);
    endfunction

    function automatic int gm(input int x, input int c);
        int s;
        s = 0;
        if (!ctrl[6])
            return x;
        for (int a = 0; a < 16; a++)
            if (x >= a * 16 + 16)
                s += gg[c][a] * 16 >> 7;
            else if (x >= a * 16)
                s += gg[c][a] * (x - a * 16) >> 7;
        return sat(s, 255);
    endfunction

    function automatic logic [5:0] ch(input int x, input int c, input logic [1:0] cl);
        int v, m;
        v = ctrl[0] ? bc(gm(x, c), c) : gm(bc(x, c), c);
        m = ctrl[1] ? int'(ctrl[3:2]) : 0;
        if (m == 1)
            v = sat((v >> 2) + v[1], 63);
        else if (m == 2)
            v = sat((v >> 2) + ((v & 3) > cl), 63);
        else
            v = v >> 2;
        return v[5:0];
    endfunction

    // Parity advances per accepted word, whatever the panel does
    task automatic px(input logic de, input logic hs, input logic vs);
        logic [23:0] v;
        logic [17:0] e;
        v = $urandom;
        for (int c = 0; c < 3; c++)
            e[c*6+:6] = ch(v[c*8+:8], c, dth[{row, col}*2+:2]);
        exp_q.push_back({de, hs, vs, e});
        if (vs)
            row = 0;
        else if (pde && !de)
            row = ~row;
        col = de ? ~col : 1'b0;
        pde = de;
        if ($urandom_range(3) == 0) begin
            pix_valid_in <= 1'b0;
            @(posedge mclk_in);
        end
        pix_valid_in <= 1'b1;
        pix_rgb_in <= v;
        pix_de_in <= de;
        pix_hsync_in <= hs;
        pix_vsync_in <= vs;
        do @(posedge mclk_in); while (!pix_ready_out);
    endtask

    task automatic burst();
        px(0, 0, 1);
        for (int l = 0; l < 2; l++) begin
            for (int k = 0; k < 4; k++)
                px(1, 0, 0);
            px(0, 1, 0);
        end
        pix_valid_in <= 1'b0;
        while (exp_q.size() != 0) @(posedge mclk_in);
    endtask

    always @(posedge mclk_in) begin
        if (rst_n_in && panel_valid_out && panel_ready_in) begin
            if (exp_q.size() == 0)
                chk("surplus", 1, 0);
            else
                chk("pixel", panel_word, exp_q.pop_front());
        end
    end

    always @(posedge mclk_in) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            error_cnt++;
            end_of_test();
        end
    end

    initial begin
        {rst_n_in, s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in, s_axi_rready_in} = '0;
        {pix_valid_in, pix_de_in, pix_hsync_in, pix_vsync_in, row, col, pde} = '0;
        {s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in, pix_rgb_in} = '0;
        s_axi_wstrb_in = 4'hF;
        void'($urandom(32854));
        for (int i = 0; i < 48; i++)
            gg[i/16][i%16] = 128;
        gg[2][15] = 64;
        gg[1][0] = 192;
        repeat (16) @(posedge mclk_in);
        rst_n_in <= 1'b1;
        wr(12'h010, 32'hFF, 2'h0);
        wr(12'h200, 32'h55, 2'h2);
        for (int i = 0; i < 7; i++)
            rd(ra[i], rv[i], 2'h0);
        rd(12'h200, 32'h0, 2'h2);
        rd(12'h020, 32'h0, 2'h2);
        wr(12'h13C, 32'h40, 2'h0);
        wr(12'h140, 32'hC0, 2'h0);
        rd(12'h13C, 32'h40, 2'h0);
        for (int i = 0; i < 128; i++) begin
            w = $urandom;
            dth = w[7:0];
            wr(12'h004, w, 2'h0);
            w = $urandom;
            brt = w[23:0];
            wr(12'h008, w, 2'h0);
            rd(12'h008, {8'h00, brt}, 2'h0);
            w = $urandom;
            con = w[23:0];
            wr(12'h00C, w, 2'h0);
            w = $urandom;
            ctrl = i[6:0];
            wr(12'h000, {w[31:7], ctrl}, 2'h0);
            rd(12'h000, {25'h0, ctrl}, 2'h0);
            burst();
        end
        end_of_test();
    end
endmodule // test_output_color_correction
